// *** hw/rsp_pkg.sv ***
package rsp_pkg;

    // ==========================================================
    // Widths
    localparam int FREQ_W = 16;
    localparam int TIME_W = 24;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 33;

    // ==========================================================
    // Timing
    localparam longint CLK_HZ   = 100_000_000;
    localparam longint MINUTE_S = 60;
    localparam logic [CNT_W-1:0] MINUTE_CYCLES_DFLT = CNT_W'(MINUTE_S * CLK_HZ);

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MAX_FREQ = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PANEL    = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_EXT      = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CURRENT  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_ACCEL1   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_DECEL1   = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_ACCEL2   = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_DECEL2   = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_OUTPUT   = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_NVM_CNT  = 8'h2C;

    // ==========================================================
    // Control field layout
    localparam int SEL_LSB  = 0;
    localparam int SEL_W    = 2;
    localparam int MODE_LSB = 2;
    localparam int MODE_W   = 3;
    localparam int USE_CUR_BIT = 5;

    // Remote function selection values
    localparam logic [SEL_W-1:0] SEL_MULTI     = 2'h0;
    localparam logic [SEL_W-1:0] SEL_STORE     = 2'h1;
    localparam logic [SEL_W-1:0] SEL_CLR_ON_STOP = 2'h3;

    // Operation mode selection values
    localparam logic [MODE_W-1:0] MODE_EXT   = 3'h0;
    localparam logic [MODE_W-1:0] MODE_PANEL = 3'h1;
    localparam logic [MODE_W-1:0] MODE_COMB3 = 3'h2;
    localparam logic [MODE_W-1:0] MODE_EXT4  = 3'h3;
    localparam logic [MODE_W-1:0] MODE_NET   = 3'h4;

    // ==========================================================
    // Reset values
    localparam logic [FREQ_W-1:0] MAX_FREQ_RST = 16'h9C40;
    localparam logic [TIME_W-1:0] TIME_RST     = 24'h000064;

    // ==========================================================
    // Types
    typedef struct packed {
        logic setpoint_increase_input;
        logic setpoint_decrease_input;
        logic setpoint_clear_input;
        logic forward_run_input;
        logic reverse_run_input;
        logic second_function_select_input;
        logic jog_active_input;
        logic pid_active_input;
    } rsp_pins_t;

    typedef struct packed {
        logic              write;
        logic [FREQ_W-1:0] data;
    } rsp_nvm_wr_t;

    typedef enum logic {RSP_BOOT, RSP_ACTIVE} rsp_state_t;

endpackage

// *** hw/rsp_remote_setpoint.sv ***
`timescale 1ns/1ps
// Summary of operation
// (R1) Sel 1..3 makes inputs up/down/clear
// (R2) Sel 1 stores setpoint, restores at power-up
// (R3) Sel 3 clears setpoint when run off
// (R4) Clear affects working copy, not memory
// (R5) Adjust added to mode-selected base frequency
// (R6) Save at stop and each idle minute
// (R7) Periodic write only when setpoint changed
// (R8) Ramp on second times, longer primary wins
// (R9) Second function forces second ramp times
// (R10) Up/down adjust even while stopped
// (R11) Jog or PID disables remote setting
// (R12) Early power return restores stored value
// (R13) Late power return restores cleared value
// (R14) Clear input zeroes remote setpoint
// (R15) Also works in network mode
// (R16) Controller picks sel 2/3 if busy
// (R17) Sel 1 restarts with direction held
// (R18) Setpoint saturates between zero and max
// (R19) Both up and down hold setpoint
module rsp_remote_setpoint
    import rsp_pkg::*;
#(
    parameter logic [rsp_pkg::CNT_W-1:0] MINUTE_CYCLES = rsp_pkg::MINUTE_CYCLES_DFLT
) (
    input  wire  logic                        core_clk,
    input  wire  logic                        sys_rst,
    input  wire  logic                        psel,
    input  wire  logic                        penable,
    input  wire  logic                        pwrite,
    input  wire  logic [rsp_pkg::ADDR_W-1:0]  paddr,
    input  wire  logic [rsp_pkg::DATA_W-1:0]  pwdata,
    output logic       [rsp_pkg::DATA_W-1:0]  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire  rsp_pkg::rsp_pins_t          pin_in,
    input  wire  logic [rsp_pkg::FREQ_W-1:0]  nvm_stored_freq,
    output rsp_pkg::rsp_nvm_wr_t              nvm_wr,
    output logic       [rsp_pkg::FREQ_W-1:0]  setpoint_freq,
    output logic       [2:0]                  multi_speed_select,
    output logic                              run_forward,
    output logic                              run_reverse,
    output logic                              remote_active
);
    import rsp_pkg::*;

    // ==========================================================
    // Pin synchronisers
    rsp_pins_t pin_meta;
    rsp_pins_t pin;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_meta <= '0;
            pin      <= '0;
        end else begin
            pin_meta <= pin_in;
            pin      <= pin_meta;
        end
    end

    // ==========================================================
    // APB register file
    rsp_state_t        state, next_state;
    logic [SEL_W-1:0]  sel, next_sel;
    logic [MODE_W-1:0] mode, next_mode;
    logic              use_cur, next_use_cur;
    logic [FREQ_W-1:0] max_freq, next_max_freq;
    logic [FREQ_W-1:0] panel_cmd, next_panel_cmd;
    logic [FREQ_W-1:0] ext_cmd, next_ext_cmd;
    logic [FREQ_W-1:0] cur_cmd, next_cur_cmd;
    logic [TIME_W-1:0] accel1, next_accel1;
    logic [TIME_W-1:0] decel1, next_decel1;
    logic [TIME_W-1:0] accel2, next_accel2;
    logic [TIME_W-1:0] decel2, next_decel2;
    logic [DATA_W-1:0] next_prdata;
    logic              next_pready;
    logic              next_pslverr;
    logic              restore, next_restore;
    logic [FREQ_W-1:0] adj;
    logic              armed;
    logic [DATA_W-1:0] nvm_count;
    logic              access;

    always_comb begin
        next_state     = state;
        next_sel       = sel;
        next_mode      = mode;
        next_use_cur   = use_cur;
        next_max_freq  = max_freq;
        next_panel_cmd = panel_cmd;
        next_ext_cmd   = ext_cmd;
        next_cur_cmd   = cur_cmd;
        next_accel1    = accel1;
        next_decel1    = decel1;
        next_accel2    = accel2;
        next_decel2    = decel2;
        next_prdata    = prdata;
        next_pslverr   = 1'b0;
        next_restore   = 1'b0;
        // No wait states: ready rises in the first access cycle only
        next_pready    = psel && !penable && !pready;
        access         = psel && penable && pready;
        if (psel && !penable) begin
            next_prdata = '0;
            case (paddr)
                OFF_CTRL:     next_prdata = DATA_W'({use_cur, mode, sel});
                OFF_MAX_FREQ: next_prdata = DATA_W'(max_freq);
                OFF_PANEL:    next_prdata = DATA_W'(panel_cmd);
                OFF_EXT:      next_prdata = DATA_W'(ext_cmd);
                OFF_CURRENT:  next_prdata = DATA_W'(cur_cmd);
                OFF_ACCEL1:   next_prdata = DATA_W'(accel1);
                OFF_DECEL1:   next_prdata = DATA_W'(decel1);
                OFF_ACCEL2:   next_prdata = DATA_W'(accel2);
                OFF_DECEL2:   next_prdata = DATA_W'(decel2);
                OFF_STATUS:   next_prdata = DATA_W'({armed, state == RSP_BOOT, remote_active, adj});
                OFF_OUTPUT:   next_prdata = DATA_W'(setpoint_freq);
                OFF_NVM_CNT:  next_prdata = nvm_count;
                default:      next_pslverr = 1'b1;
            endcase
        end
        if (access && pwrite) begin
            case (paddr)
                OFF_CTRL: begin
                    next_sel     = pwdata[SEL_LSB +: SEL_W];
                    next_mode    = pwdata[MODE_LSB +: MODE_W];
                    next_use_cur = pwdata[USE_CUR_BIT];
                    // (R2) Restore on first setup
                    if (state == RSP_BOOT) begin
                        next_state   = RSP_ACTIVE;
                        next_restore = (pwdata[SEL_LSB +: SEL_W] == SEL_STORE);
                    end
                end
                OFF_MAX_FREQ: next_max_freq  = pwdata[FREQ_W-1:0];
                OFF_PANEL:    next_panel_cmd = pwdata[FREQ_W-1:0];
                OFF_EXT:      next_ext_cmd   = pwdata[FREQ_W-1:0];
                OFF_CURRENT:  next_cur_cmd   = pwdata[FREQ_W-1:0];
                OFF_ACCEL1:   next_accel1    = pwdata[TIME_W-1:0];
                OFF_DECEL1:   next_decel1    = pwdata[TIME_W-1:0];
                OFF_ACCEL2:   next_accel2    = pwdata[TIME_W-1:0];
                OFF_DECEL2:   next_decel2    = pwdata[TIME_W-1:0];
                default:      next_state     = state;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state     <= RSP_BOOT;
            sel       <= SEL_MULTI;
            mode      <= MODE_EXT;
            use_cur   <= 1'b0;
            max_freq  <= MAX_FREQ_RST;
            panel_cmd <= '0;
            ext_cmd   <= '0;
            cur_cmd   <= '0;
            accel1    <= TIME_RST;
            decel1    <= TIME_RST;
            accel2    <= TIME_RST;
            decel2    <= TIME_RST;
            prdata    <= '0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            restore   <= 1'b0;
        end else begin
            state     <= next_state;
            sel       <= next_sel;
            mode      <= next_mode;
            use_cur   <= next_use_cur;
            max_freq  <= next_max_freq;
            panel_cmd <= next_panel_cmd;
            ext_cmd   <= next_ext_cmd;
            cur_cmd   <= next_cur_cmd;
            accel1    <= next_accel1;
            decel1    <= next_decel1;
            accel2    <= next_accel2;
            decel2    <= next_decel2;
            prdata    <= next_prdata;
            pready    <= next_pready;
            pslverr   <= next_pslverr;
            restore   <= next_restore;
        end
    end

    // ==========================================================
    // Setpoint adjust and ramp
    logic [FREQ_W-1:0] next_adj, next_setpoint, base;
    logic [TIME_W-1:0] ramp_cnt, next_ramp_cnt, period;
    logic [1:0]        ramp_dir, next_ramp_dir;
    logic [2:0]        next_mss;
    logic              next_remote, next_armed, next_fwd, next_rev;
    logic              going_up, going_dn, do_clear;
    logic [FREQ_W:0]   sum;

    always_comb begin
        // (R1) Remote function reinterprets inputs
        // (R11) Jog or PID blocks it
        next_remote = (sel != SEL_MULTI) && !pin.jog_active_input && !pin.pid_active_input;
        next_mss    = (sel == SEL_MULTI) ? {pin.setpoint_increase_input,
                      pin.setpoint_decrease_input, pin.setpoint_clear_input} : 3'h0;
        // (R19) Both pressed hold
        going_up    = pin.setpoint_increase_input && !pin.setpoint_decrease_input;
        going_dn    = pin.setpoint_decrease_input && !pin.setpoint_increase_input;
        // (R8) Longer primary wins
        // (R9) Second function forces second
        if (going_up) begin
            period = (pin.second_function_select_input || accel2 >= accel1) ? accel2 : accel1;
        end else begin
            period = (pin.second_function_select_input || decel2 >= decel1) ? decel2 : decel1;
        end
        // (R14) Clear to zero
        // (R3) Clear when both run inputs off
        do_clear = pin.setpoint_clear_input || ((sel == SEL_CLR_ON_STOP)
                   && !pin.forward_run_input && !pin.reverse_run_input);
        next_adj      = adj;
        next_ramp_dir = {going_up, going_dn};
        next_ramp_cnt = '0;
        // (R10) Adjust regardless of run state
        if (remote_active && (going_up || going_dn) && ramp_dir == next_ramp_dir) begin
            next_ramp_cnt = ramp_cnt + 1'b1;
            if (ramp_cnt >= period) begin
                next_ramp_cnt = '0;
                // (R18) Saturate at limits
                if (going_up) begin
                    next_adj = (adj >= max_freq) ? max_freq : adj + 1'b1;
                end else begin
                    next_adj = (adj == '0) ? '0 : adj - 1'b1;
                end
            end
        end
        // (R4) Working copy only
        if (remote_active && do_clear) begin
            next_adj = '0;
        end
        // (R2) Load stored value
        if (restore) begin
            next_adj = (nvm_stored_freq > max_freq) ? max_freq : nvm_stored_freq;
        end
        // (R5) Base by operation mode
        // (R15) Network mode uses external
        case (mode)
            MODE_PANEL: base = panel_cmd;
            MODE_COMB3: base = use_cur ? cur_cmd : panel_cmd;
            default:    base = ext_cmd;
        endcase
        sum = {1'b0, base} + (remote_active ? {1'b0, adj} : '0);
        next_setpoint = (sum > {1'b0, max_freq}) ? max_freq : sum[FREQ_W-1:0];
        // (R17) Auto restart for any sel: synchronised pins read zero just after reset
        next_armed = armed || restore
                     || (!pin.forward_run_input && !pin.reverse_run_input);
        next_fwd   = next_armed && pin.forward_run_input;
        next_rev   = next_armed && pin.reverse_run_input && !pin.forward_run_input;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            adj                <= '0;
            ramp_cnt           <= '0;
            ramp_dir           <= '0;
            setpoint_freq      <= '0;
            multi_speed_select <= '0;
            remote_active      <= 1'b0;
            armed              <= 1'b0;
            run_forward        <= 1'b0;
            run_reverse        <= 1'b0;
        end else begin
            adj                <= next_adj;
            ramp_cnt           <= next_ramp_cnt;
            ramp_dir           <= next_ramp_dir;
            setpoint_freq      <= next_setpoint;
            multi_speed_select <= next_mss;
            remote_active      <= next_remote;
            armed              <= next_armed;
            run_forward        <= next_fwd;
            run_reverse        <= next_rev;
        end
    end

    // ==========================================================
    // Nonvolatile store scheduling
    // Storing wears the memory; a busy controller should run sel 2 or 3
    logic [CNT_W-1:0]  idle_cnt, next_idle_cnt;
    logic [FREQ_W-1:0] last_cmp, next_last_cmp;
    logic [1:0]        ud_prev, next_ud_prev;
    logic              run_prev, next_run_prev;
    logic [DATA_W-1:0] next_nvm_count;
    rsp_nvm_wr_t       next_nvm_wr;
    logic              store_en, tick;

    always_comb begin
        store_en       = (sel == SEL_STORE) && (state == RSP_ACTIVE);
        next_ud_prev   = {pin.setpoint_increase_input, pin.setpoint_decrease_input};
        next_run_prev  = pin.forward_run_input || pin.reverse_run_input;
        next_last_cmp  = last_cmp;
        next_nvm_count = nvm_count;
        next_nvm_wr    = '{write: 1'b0, data: adj};
        // (R6) Minute timer restarts on up/down change
        tick           = (idle_cnt >= MINUTE_CYCLES - 1'b1);
        next_idle_cnt  = tick ? '0 : idle_cnt + 1'b1;
        if (next_ud_prev != ud_prev) begin
            next_idle_cnt = '0;
            tick          = 1'b0;
        end
        // (R7) Periodic write only on change
        // (R12) Clear inside first minute never written
        // (R13) Clear after a minute is written
        if (store_en && tick) begin
            next_last_cmp     = adj;
            next_nvm_wr.write = (adj != last_cmp);
        end
        // (R6) Save when start drops
        if (store_en && run_prev && !next_run_prev) begin
            next_nvm_wr.write = 1'b1;
        end
        if (next_nvm_wr.write) begin
            next_nvm_count = nvm_count + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            idle_cnt  <= '0;
            last_cmp  <= '0;
            ud_prev   <= '0;
            run_prev  <= 1'b0;
            nvm_count <= '0;
            nvm_wr    <= '0;
        end else begin
            idle_cnt  <= next_idle_cnt;
            last_cmp  <= next_last_cmp;
            ud_prev   <= next_ud_prev;
            run_prev  <= next_run_prev;
            nvm_count <= next_nvm_count;
            nvm_wr    <= next_nvm_wr;
        end
    end

endmodule

// *** test/rsp_contacts.sv ***
`timescale 1ns/1ps
// ==========
// Contact inputs and nonvolatile store
module rsp_contacts
    import rsp_pkg::*;
#(
    parameter logic [rsp_pkg::FREQ_W-1:0] INIT = 16'h0020
) (
    input  wire logic                          core_clk,
    input  wire rsp_pkg::rsp_pins_t            cmd,
    input  wire rsp_pkg::rsp_nvm_wr_t          nvm_wr,
    output rsp_pkg::rsp_pins_t                 pin_in,
    output logic       [rsp_pkg::FREQ_W-1:0]   nvm_stored_freq
);
    // Store is never reset, so its word outlives every power cycle
    initial nvm_stored_freq = INIT;
    initial pin_in = '0;
    always @(posedge core_clk) begin
        if (nvm_wr.write === 1'b1) begin
            nvm_stored_freq <= nvm_wr.data;
        end
    end
    // Contacts settle one edge after the controller moves them
    always @(posedge core_clk) begin
        pin_in <= cmd;
    end
endmodule

// *** test/rsp_chk.sv ***
`timescale 1ns/1ps
module rsp_chk
    import rsp_pkg::*;
(
    input wire logic                        core_clk,
    input wire logic                        sys_rst,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire rsp_pkg::rsp_pins_t          pin_in,
    input wire rsp_pkg::rsp_nvm_wr_t        nvm_wr,
    input wire logic [rsp_pkg::FREQ_W-1:0]  setpoint_freq,
    input wire logic [2:0]                  multi_speed_select,
    input wire logic                        run_forward,
    input wire logic                        run_reverse,
    input wire logic                        remote_active
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ==========
    // Bus answer and outputs after reset
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_reset_clean: assert property ($fell(sys_rst) |-> !remote_active && setpoint_freq == '0)
        else $error("outputs not clear after reset");
    // ==========
    // Pin behaviour
    a_multi_or_remote: assert property (|multi_speed_select |-> !remote_active)
        else $error("multi speed select while remote active");
    a_jog_pid_block: assert property (
        (pin_in.jog_active_input || pin_in.pid_active_input)[*5] |-> !remote_active)
        else $error("remote active during jog or pid");
    a_both_hold: assert property (
        (pin_in.setpoint_increase_input && pin_in.setpoint_decrease_input && !psel
        && $stable(pin_in))[*6] |-> $stable(setpoint_freq))
        else $error("setpoint moved with both inputs held");
    a_run_one_dir: assert property (!(run_forward && run_reverse))
        else $error("both run outputs high");
    c_nvm_write: cover property (nvm_wr.write);
    c_bus_error: cover property (pslverr);
    c_remote_on: cover property ($rose(remote_active));
endmodule
bind rsp_remote_setpoint rsp_chk u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .nvm_wr(nvm_wr),
    .setpoint_freq(setpoint_freq), .multi_speed_select(multi_speed_select),
    .run_forward(run_forward), .run_reverse(run_reverse), .remote_active(remote_active)
);

// *** test/test_remote_speed_setpoint_pot.sv ***
`timescale 1ns/1ps
module test_remote_speed_setpoint_pot;
    import rsp_pkg::*;
    // Short minute keeps the run brief
    localparam logic [CNT_W-1:0] MIN_CYC = 33'h32;
    localparam rsp_pins_t P_INC = 8'h80;
    localparam rsp_pins_t P_DEC = 8'h40;
    localparam rsp_pins_t P_CLR = 8'h20;
    localparam rsp_pins_t P_FWD = 8'h10;
    localparam rsp_pins_t P_RT  = 8'h04;
    localparam rsp_pins_t P_JOG = 8'h02;
    localparam rsp_pins_t P_PID = 8'h01;
    logic              core_clk = 1'b0;
    logic              sys_rst  = 1'b1;
    logic              psel     = 1'b0;
    logic              penable  = 1'b0;
    logic              pwrite   = 1'b0;
    logic [ADDR_W-1:0] paddr    = '0;
    logic [DATA_W-1:0] pwdata   = '0;
    rsp_pins_t         cmd      = '0;
    logic [DATA_W-1:0] prdata, rd, c;
    logic              pready, pslverr, err, run_f, run_r, ract;
    rsp_pins_t         pin_in;
    rsp_nvm_wr_t       nvm_wr;
    logic [FREQ_W-1:0] nvm_q, setpoint_freq, a;
    logic [2:0]        msel;
    logic [5:0]        mc [5] = '{6'h02, 6'h06, 6'h0A, 6'h2A, 6'h0E};
    logic [15:0]       mb [5] = '{16'h0100, 16'h0200, 16'h0200, 16'h0300, 16'h0100};
    int                n_mismatch = 0;
    int                tests_run  = 0;

    always #5 core_clk = ~core_clk;

    rsp_remote_setpoint #(.MINUTE_CYCLES(MIN_CYC)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .nvm_stored_freq(nvm_q),
        .nvm_wr(nvm_wr), .setpoint_freq(setpoint_freq), .multi_speed_select(msel),
        .run_forward(run_f), .run_reverse(run_r), .remote_active(ract)
    );
    rsp_contacts u_far (
        .core_clk(core_clk), .cmd(cmd), .nvm_wr(nvm_wr), .pin_in(pin_in),
        .nvm_stored_freq(nvm_q)
    );

    // ==========
    // Tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only pready or the watchdog ends a wait for the answer
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask
    task automatic rchk(input string w, input logic [7:0] ad, input logic [31:0] e);
        apb(1'b0, ad, 32'h0);
        chk(w, e, rd);
    endtask
    task automatic radj(input logic [15:0] e);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("adj", e, rd[15:0]);
    endtask
    // Edges between two consecutive setpoint moves
    task automatic gap(input int e);
        logic [FREQ_W-1:0] s;
        int t;
        for (int k = 0; k < 2; k++) begin
            s = setpoint_freq;
            t = 0;
            while (setpoint_freq === s && t < 200) begin
                @(posedge core_clk);
                t++;
            end
        end
        chk("step gap", e, t);
    endtask
    task automatic power;
        sys_rst <= 1'b1;
        cyc(20);
        sys_rst <= 1'b0;
        wr(OFF_ACCEL2, 32'h4);
        wr(OFF_CTRL, 32'h1);
        cyc(4);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        cyc(20000);
        n_mismatch++;
        wrap_up;
    end

    // ==========
    // Sequence
    initial begin
        cyc(20);
        sys_rst <= 1'b0;
        rchk("max", OFF_MAX_FREQ, 32'h9C40);
        rchk("accel2", OFF_ACCEL2, 32'h64);
        wr(OFF_OUTPUT, 32'hFFFF);
        rchk("output", OFF_OUTPUT, 32'h0);
        rchk("unmapped", 8'h40, 32'h0);
        chk("slverr", 1'b1, err);
        wr(OFF_EXT, 32'h100);
        wr(OFF_PANEL, 32'h200);
        wr(OFF_CURRENT, 32'h300);
        wr(OFF_ACCEL1, 32'h2);
        wr(OFF_ACCEL2, 32'h4);
        wr(OFF_DECEL2, 32'h4);
        wr(OFF_CTRL, 32'h0);
        cmd <= P_INC | P_CLR;
        cyc(5);
        chk("multi", 3'h5, msel);
        for (int s = 1; s < 4; s++) begin
            wr(OFF_CTRL, 32'(s));
            cyc(3);
            chk("multi", 3'h0, msel);
            chk("remote", 1'b1, ract);
        end
        // Storage off while inputs move a lot
        wr(OFF_CTRL, 32'h2);
        cmd <= P_INC;
        gap(5);
        wr(OFF_ACCEL1, 32'h9);
        gap(10);
        cmd <= P_INC | P_RT;
        gap(5);
        cmd <= P_INC | P_DEC;
        cyc(12);
        wr(OFF_MAX_FREQ, 32'h104);
        cmd <= P_INC | P_RT;
        cyc(1400);
        chk("ceiling", 16'h104, setpoint_freq);
        radj(16'h104);
        cmd <= P_DEC | P_RT;
        cyc(1400);
        chk("floor", 16'h100, setpoint_freq);
        radj(16'h0);
        wr(OFF_MAX_FREQ, 32'h9C40);
        cmd <= P_INC | P_RT;
        cyc(30);
        cmd <= P_CLR;
        cyc(5);
        radj(16'h0);
        for (int i = 0; i < 5; i++) begin
            wr(OFF_CTRL, {26'h0, mc[i]});
            cyc(3);
            chk("base", mb[i], setpoint_freq);
        end
        wr(OFF_CTRL, 32'h12);
        cyc(3);
        chk("network", 1'b1, ract);
        cmd <= P_JOG;
        cyc(5);
        chk("jog", 1'b0, ract);
        cmd <= P_PID;
        cyc(5);
        chk("pid", 1'b0, ract);
        wr(OFF_CTRL, 32'h3);
        cmd <= P_FWD | P_INC | P_RT;
        cyc(40);
        cmd <= P_INC | P_RT;
        cyc(5);
        radj(16'h0);
        cmd <= P_FWD;
        power;
        radj(16'h20);
        chk("restored", 16'h20, setpoint_freq);
        chk("restart", 1'b1, run_f);
        chk("reverse", 1'b0, run_r);
        cmd <= P_FWD | P_INC | P_RT;
        cyc(30);
        cmd <= P_FWD;
        cyc(5);
        apb(1'b0, OFF_STATUS, 32'h0);
        a = rd[15:0];
        cmd <= 8'h00;
        cyc(6);
        chk("stop save", a, nvm_q);
        cyc(60);
        apb(1'b0, OFF_NVM_CNT, 32'h0);
        c = rd;
        cyc(110);
        rchk("no rewrite", OFF_NVM_CNT, c);
        cmd <= P_INC | P_RT;
        cyc(30);
        cmd <= P_CLR;
        cyc(6);
        chk("kept", a, nvm_q);
        cmd <= 8'h00;
        power;
        radj(a);
        cmd <= P_INC | P_RT;
        cyc(30);
        cmd <= 8'h00;
        cyc(60);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("tick save", rd[15:0], nvm_q);
        cmd <= P_CLR;
        cyc(60);
        chk("clear saved", 16'h0, nvm_q);
        cmd <= 8'h00;
        power;
        radj(16'h0);
        wrap_up;
    end
endmodule
